/* rtl/bsc_pkg.sv */
// Constants for the boot strap configuration latch.
// Assumes a 10 MHz device clock and a 32-bit Avalon-MM register port.
package bsc_pkg;

  // ----------------------------------------------------------------------
  // Clock and serial timing
  // ----------------------------------------------------------------------
  localparam int CLK_NS      = 100;
  localparam int BIT_NS      = 8700;
  localparam int BIT_CYC     = (BIT_NS / CLK_NS) < 1 ? 1 : (BIT_NS / CLK_NS);
  localparam int BOOT_FRAMES = 4;

  localparam logic [7:0] BOOT_MSG_BYTE = 8'h55;

  // ----------------------------------------------------------------------
  // Strap vector layout
  // ----------------------------------------------------------------------
  localparam int STRAP_W        = 5;
  localparam int STRAP_BOOT_LSB = 0;
  localparam int STRAP_BOOT_MSB = 1;
  localparam int STRAP_PRINT    = 2;
  localparam int STRAP_EDGE_LO  = 3;
  localparam int STRAP_VSEL     = 4;

  // Internal defaults: boot 10, print 1, edge field 11, voltage 1
  localparam logic [STRAP_W-1:0] STRAP_DEFAULT = 5'h1E;

  localparam logic [1:0] BOOT_DOWNLOAD = 2'h0;
  localparam logic [1:0] BOOT_RESERVED = 2'h1;

  // ----------------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------------
  localparam int         ADDR_W      = 4;
  localparam logic [3:0] REG_STATUS  = 4'h0;
  localparam logic [3:0] REG_CONTROL = 4'h4;
  localparam logic [3:0] REG_STRAPS  = 4'h8;

  localparam int CTRL_REPRINT = 0;
  localparam int CTRL_MUTE    = 1;

  localparam int ST_BOOT_LSB   = 0;
  localparam int ST_RESERVED   = 2;
  localparam int ST_VSEL       = 3;
  localparam int ST_PRINT      = 4;
  localparam int ST_IN_RISING  = 5;
  localparam int ST_OUT_RISING = 6;
  localparam int ST_CAPTURED   = 7;
  localparam int ST_TX_BUSY    = 8;

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} bsc_tx_state_t;

endpackage

/* rtl/bsc_strap_sampler.sv */
// Strap sampler: merges fitted straps with internal defaults, latches once.
// Assumes strap inputs synchronous to clk_i and stable through start-up.
`timescale 1ns/1ns
`default_nettype none
module bsc_strap_sampler #(
  parameter int W = bsc_pkg::STRAP_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] strap_pins_i,
  input  wire logic [W-1:0] strap_fitted_i,
  output logic      [W-1:0] straps_o,
  output logic              captured_o
);

  logic [W-1:0] next_straps;
  logic         next_captured;
  logic [W-1:0] merged;

  // ----------------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------------
  always_comb begin
    merged        = (strap_pins_i & strap_fitted_i)
                  | (bsc_pkg::STRAP_DEFAULT[W-1:0] & ~strap_fitted_i);
    next_straps   = straps_o;
    next_captured = captured_o;
    if (!captured_o) begin
      next_straps   = merged;
      next_captured = 1'b1;
    end
  end

  // Reset takes constants only; the pins are caught on the first edge after
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      straps_o   <= '0;
      captured_o <= 1'b0;
    end else begin
      straps_o   <= next_straps;
      captured_o <= next_captured;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_default_fill: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(captured_o) |-> straps_o == (($past(strap_pins_i) & $past(strap_fitted_i))
      | (bsc_pkg::STRAP_DEFAULT[W-1:0] & ~$past(strap_fitted_i))))
    else $error("Strap default merge wrong");

  a_hold_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    captured_o ##1 captured_o |-> $stable(straps_o))
    else $error("Latched straps changed after capture");

  a_reset_clears: assert property (@(posedge clk_i)
    rst_i |-> !captured_o)
    else $error("Capture flag set during reset");

endmodule
`default_nettype wire

/* rtl/bsc_boot_strap_config_latch.sv */
// Boot strap configuration latch: decode, boot debug print, register port.
// Assumes straps held by board resistors through start-up; Avalon-MM master.
//
// Functional notes
// - Boot field 00 download, 01 reserved, 10 or 11 flash boot.
// - Voltage strap 0 selects 3.3V supply, 1 selects 1.8V; board straps 1.8V.
// - Print strap 0 keeps serial transmit silent, 1 sends boot debug text.
// - Edge field {print, edge_lo}: upper bit input edge, lower bit output edge.
// - Unfitted straps take defaults: boot 10, print 1, edges 11, voltage 1.
// - Hardware reset restarts the block and triggers a new capture.
`timescale 1ns/1ns
`default_nettype none
module bsc_boot_strap_config_latch #(
  parameter int BIT_CYC = bsc_pkg::BIT_CYC,
  parameter int FRAMES  = bsc_pkg::BOOT_FRAMES
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic [bsc_pkg::STRAP_W-1:0] strap_pins_i,
  input  wire logic [bsc_pkg::STRAP_W-1:0] strap_fitted_i,
  input  wire logic [bsc_pkg::ADDR_W-1:0]  avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [31:0]                avs_writedata_i,
  input  wire logic [3:0]                 avs_byteenable_i,
  output logic      [31:0]                avs_readdata_o,
  output logic                            avs_waitrequest_o,
  output logic                            config_valid_o,
  output logic                            boot_download_o,
  output logic                            boot_flash_o,
  output logic                            boot_reserved_o,
  output logic                            flash_vsel_1v8_o,
  output logic                            sdio_in_rising_o,
  output logic                            sdio_out_rising_o,
  output logic                            primary_serial_port_tx_o
);

  // ----------------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------------
  logic [bsc_pkg::STRAP_W-1:0] straps;
  logic                        captured;
  logic                        captured_d;

  bsc_strap_sampler #(
    .W (bsc_pkg::STRAP_W)
  ) u_sampler (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .strap_pins_i   (strap_pins_i),
    .strap_fitted_i (strap_fitted_i),
    .straps_o       (straps),
    .captured_o     (captured)
  );

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic [1:0] boot_field;
  logic       next_download;
  logic       next_flash;
  logic       next_reserved;
  logic       next_vsel;
  logic       next_in_rising;
  logic       next_out_rising;

  assign boot_field = straps[bsc_pkg::STRAP_BOOT_MSB:bsc_pkg::STRAP_BOOT_LSB];

  always_comb begin
    next_download   = captured && (boot_field == bsc_pkg::BOOT_DOWNLOAD);
    next_reserved   = captured && (boot_field == bsc_pkg::BOOT_RESERVED);
    next_flash      = captured && boot_field[1];
    next_vsel       = captured ? straps[bsc_pkg::STRAP_VSEL] : 1'b1;
    next_in_rising  = straps[bsc_pkg::STRAP_PRINT];
    next_out_rising = straps[bsc_pkg::STRAP_EDGE_LO];
  end

  // Voltage select sits at 1.8V until capture: the safe supply level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      config_valid_o    <= 1'b0;
      boot_download_o   <= 1'b0;
      boot_flash_o      <= 1'b0;
      boot_reserved_o   <= 1'b0;
      flash_vsel_1v8_o  <= 1'b1;
      sdio_in_rising_o  <= 1'b0;
      sdio_out_rising_o <= 1'b0;
      captured_d        <= 1'b0;
    end else begin
      config_valid_o    <= captured;
      boot_download_o   <= next_download;
      boot_flash_o      <= next_flash;
      boot_reserved_o   <= next_reserved;
      flash_vsel_1v8_o  <= next_vsel;
      sdio_in_rising_o  <= next_in_rising;
      sdio_out_rising_o <= next_out_rising;
      captured_d        <= captured;
    end
  end

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  logic        ack;
  logic        next_ack;
  logic        req;
  logic        ctrl_mute;
  logic        next_mute;
  logic        reprint;
  logic [31:0] next_rdata;
  logic        tx_busy;

  assign req               = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = req && !ack;

  always_comb begin
    next_ack   = req && !ack;
    next_mute  = ctrl_mute;
    reprint    = 1'b0;
    next_rdata = avs_readdata_o;
    if (req && ack && avs_write_i && avs_address_i == bsc_pkg::REG_CONTROL
        && avs_byteenable_i[0]) begin
      next_mute = avs_writedata_i[bsc_pkg::CTRL_MUTE];
      reprint   = avs_writedata_i[bsc_pkg::CTRL_REPRINT];
    end
    if (avs_read_i && !ack) begin
      next_rdata = 32'h0000_0000;
      unique case (avs_address_i)
        bsc_pkg::REG_STATUS: begin
          next_rdata[bsc_pkg::ST_BOOT_LSB +: 2] = boot_field;
          next_rdata[bsc_pkg::ST_RESERVED]      = boot_reserved_o;
          next_rdata[bsc_pkg::ST_VSEL]          = flash_vsel_1v8_o;
          next_rdata[bsc_pkg::ST_PRINT]         = straps[bsc_pkg::STRAP_PRINT];
          next_rdata[bsc_pkg::ST_IN_RISING]     = sdio_in_rising_o;
          next_rdata[bsc_pkg::ST_OUT_RISING]    = sdio_out_rising_o;
          next_rdata[bsc_pkg::ST_CAPTURED]      = captured;
          next_rdata[bsc_pkg::ST_TX_BUSY]       = tx_busy;
        end
        bsc_pkg::REG_CONTROL: begin
          next_rdata[bsc_pkg::CTRL_MUTE] = ctrl_mute;
        end
        bsc_pkg::REG_STRAPS: begin
          next_rdata[bsc_pkg::STRAP_W-1:0] = straps;
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack            <= 1'b0;
      ctrl_mute      <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      ack            <= next_ack;
      ctrl_mute      <= next_mute;
      avs_readdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Boot debug transmitter
  // ----------------------------------------------------------------------
  // Fixed text only; software cannot supply characters before it runs
  bsc_pkg::bsc_tx_state_t state;
  bsc_pkg::bsc_tx_state_t next_state;
  logic [15:0] baud_cnt;
  logic [15:0] next_baud_cnt;
  logic [2:0]  bit_cnt;
  logic [2:0]  next_bit_cnt;
  logic [7:0]  frame_cnt;
  logic [7:0]  next_frame_cnt;
  logic [7:0]  shreg;
  logic [7:0]  next_shreg;
  logic        next_tx;
  logic        start;
  logic        baud_tick;

  assign start     = straps[bsc_pkg::STRAP_PRINT] && !ctrl_mute
                   && ((captured && !captured_d) || reprint);
  assign baud_tick = (baud_cnt == 16'(BIT_CYC - 1));
  assign tx_busy   = (state != bsc_pkg::TX_IDLE);

  always_comb begin
    next_state     = state;
    next_baud_cnt  = baud_tick ? 16'h0000 : baud_cnt + 16'h0001;
    next_bit_cnt   = bit_cnt;
    next_frame_cnt = frame_cnt;
    next_shreg     = shreg;
    next_tx        = primary_serial_port_tx_o;
    unique case (state)
      bsc_pkg::TX_IDLE: begin
        next_baud_cnt = 16'h0000;
        next_tx       = 1'b1;
        if (start) begin
          next_state     = bsc_pkg::TX_START;
          next_frame_cnt = 8'(FRAMES - 1);
          next_shreg     = bsc_pkg::BOOT_MSG_BYTE;
          next_tx        = 1'b0;
        end
      end
      bsc_pkg::TX_START: begin
        if (baud_tick) begin
          next_state   = bsc_pkg::TX_DATA;
          next_bit_cnt = 3'h0;
          next_tx      = shreg[0];
          next_shreg   = {1'b0, shreg[7:1]};
        end
      end
      bsc_pkg::TX_DATA: begin
        if (baud_tick) begin
          if (bit_cnt == 3'h7) begin
            next_state = bsc_pkg::TX_STOP;
            next_tx    = 1'b1;
          end else begin
            next_bit_cnt = bit_cnt + 3'h1;
            next_tx      = shreg[0];
            next_shreg   = {1'b0, shreg[7:1]};
          end
        end
      end
      bsc_pkg::TX_STOP: begin
        if (baud_tick) begin
          if (frame_cnt == 8'h00) begin
            next_state = bsc_pkg::TX_IDLE;
          end else begin
            next_state     = bsc_pkg::TX_START;
            next_frame_cnt = frame_cnt - 8'h01;
            next_shreg     = bsc_pkg::BOOT_MSG_BYTE;
            next_tx        = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state                    <= bsc_pkg::TX_IDLE;
      baud_cnt                 <= 16'h0000;
      bit_cnt                  <= 3'h0;
      frame_cnt                <= 8'h00;
      shreg                    <= 8'h00;
      primary_serial_port_tx_o <= 1'b1;
    end else begin
      state                    <= next_state;
      baud_cnt                 <= next_baud_cnt;
      bit_cnt                  <= next_bit_cnt;
      frame_cnt                <= next_frame_cnt;
      shreg                    <= next_shreg;
      primary_serial_port_tx_o <= next_tx;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_boot_download: assert property (
    captured && boot_field == 2'h0 |=> boot_download_o && !boot_flash_o && !boot_reserved_o)
    else $error("Download boot not decoded");

  a_boot_flash: assert property (
    captured && boot_field[1] |=> boot_flash_o && !boot_download_o && !boot_reserved_o)
    else $error("Flash boot not decoded");

  a_boot_reserved: assert property (
    captured && boot_field == 2'h1 |=> boot_reserved_o && !boot_flash_o && !boot_download_o)
    else $error("Reserved boot code not flagged");

  a_vsel_map: assert property (
    captured |=> flash_vsel_1v8_o == $past(straps[bsc_pkg::STRAP_VSEL]))
    else $error("Flash supply select wrong");

  a_silent_line: assert property (
    captured && !straps[bsc_pkg::STRAP_PRINT] && !tx_busy |=> primary_serial_port_tx_o)
    else $error("Serial line not silent");

  a_print_start: assert property (
    $rose(captured) && straps[bsc_pkg::STRAP_PRINT] && !ctrl_mute
      |=> ##1 tx_busy && !primary_serial_port_tx_o)
    else $error("Boot print did not start");

  a_sdio_edges: assert property (
    captured |=> sdio_in_rising_o == $past(straps[bsc_pkg::STRAP_PRINT])
      && sdio_out_rising_o == $past(straps[bsc_pkg::STRAP_EDGE_LO]))
    else $error("SDIO edge decode wrong");

  a_wait_state: assert property (
    req && !ack |=> !avs_waitrequest_o || !req)
    else $error("Bus answer late");

  c_download_boot: cover property (captured && boot_field == 2'h0);
  c_print_done:    cover property (state == bsc_pkg::TX_STOP && baud_tick && frame_cnt == 8'h00);
  c_status_read:   cover property (avs_read_i && ack && avs_address_i == bsc_pkg::REG_STATUS);
  c_reprint:       cover property (reprint && start);

endmodule
`default_nettype wire

/* verification/bsc_strap_board.sv */
// Board strap resistors facing the boot strap configuration latch.
// Assumes the bench changes levels and fitted mask only while reset is held.
`timescale 1ns/1ns
`default_nettype none
module bsc_strap_board (
  input  wire logic [bsc_pkg::STRAP_W-1:0] level_i,
  input  wire logic [bsc_pkg::STRAP_W-1:0] fitted_i,
  input  wire logic                        wiggle_i,
  output logic      [bsc_pkg::STRAP_W-1:0] pins_o,
  output logic      [bsc_pkg::STRAP_W-1:0] fitted_o
);
  // ----------------------------------------------------------------------
  // Resistor levels
  // ----------------------------------------------------------------------
  // Open pins show the inverse default, so reading them instead is caught
  always_comb begin
    fitted_o = fitted_i;
    pins_o   = (level_i & fitted_i) | (~bsc_pkg::STRAP_DEFAULT & ~fitted_i);
    if (wiggle_i) begin
      pins_o = ~pins_o; // Broken hold, only on bench command
    end
  end
endmodule
`default_nettype wire

/* verification/tb_boot_strap_config_latch.sv */
// Testbench for the boot strap configuration latch.
// Assumes the board model above and an Avalon-MM slave with one wait state.
`timescale 1ns/1ns
`default_nettype none
module tb_boot_strap_config_latch;
  localparam int BC = 2;
  logic        clk_i     = 1'b0;
  logic        rst_i     = 1'b1;
  logic [4:0]  lvl       = 5'h1E;
  logic [4:0]  fit       = 5'h1F;
  logic        wig       = 1'b0;
  logic [3:0]  addr      = 4'h0;
  logic        rd        = 1'b0;
  logic        wr        = 1'b0;
  logic [31:0] wdata     = 32'h0;
  logic [3:0]  be        = 4'hF;
  logic        wait_q    = 1'b0;
  logic        rec       = 1'b0;
  logic [4:0]  pins;
  logic [4:0]  fitted;
  logic [31:0] rdata;
  logic [31:0] rdata_q;
  logic [31:0] v;
  logic        wreq;
  logic        cval;
  logic        bdl;
  logic        bfl;
  logic        brs;
  logic        vsel;
  logic        inr;
  logic        outr;
  logic        tx;
  logic        txq[$];
  int          error_cnt = 0;
  int          compares  = 0;

  // ----------------------------------------------------------------------
  // Clock, board and design
  // ----------------------------------------------------------------------
  always #50 clk_i = ~clk_i;

  // Mid-cycle copies hold what the next rising edge samples
  always @(negedge clk_i) begin
    wait_q  = wreq;
    rdata_q = rdata;
    if (rec) begin
      txq.push_back(tx);
    end
  end

  bsc_strap_board board_u (.level_i(lvl), .fitted_i(fit), .wiggle_i(wig),
    .pins_o(pins), .fitted_o(fitted));

  bsc_boot_strap_config_latch #(.BIT_CYC(BC), .FRAMES(1)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .strap_pins_i(pins), .strap_fitted_i(fitted),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .config_valid_o(cval), .boot_download_o(bdl),
    .boot_flash_o(bfl), .boot_reserved_o(brs), .flash_vsel_1v8_o(vsel),
    .sdio_in_rising_o(inr), .sdio_out_rising_o(outr),
    .primary_serial_port_tx_o(tx));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic summarize();
    $display("errors %0d, compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Edge first, so a release never meets a new request in one time step
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    be    <= b;
    rd    <= !w;
    wr    <= w;
    do begin
      @(posedge clk_i);
      n++;
    end while (wait_q && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("mismatch at %0t: no bus answer", $time);
    end
    v = rdata_q;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic start(input logic [4:0] l, input logic [4:0] f);
    @(posedge clk_i);
    rst_i <= 1'b1;
    wig   <= 1'b0;
    lvl   <= l;
    fit   <= f;
    repeat (6) @(posedge clk_i);
    check({29'h0, vsel, tx, cval}, 32'h6);
    rec = 1'b0;
    txq.delete();
    rst_i <= 1'b0;
    rec = 1'b1;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic expect_cfg(input logic [4:0] p);
    check({31'h0, cval}, 32'h1);
    check({30'h0, bdl, bfl}, {30'h0, p[1:0] == 2'h0, p[1]});
    check({31'h0, brs}, {31'h0, p[1:0] == 2'h1});
    check({31'h0, vsel}, {31'h0, p[4]});
    check({30'h0, inr, outr}, {30'h0, p[2], p[3]});
    bus(1'b0, 4'h8, 32'h0, 4'hF);
    check(v, {27'h0, p});
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    check({24'h0, v[7:0]}, {24'h0, 1'b1, p[3], p[2], p[2], p[4], p[1:0] == 2'h1, p[1:0]});
  endtask

  // One 8N1 frame of 8'h55 expected, or a silent line
  task automatic frame(input logic exp);
    int s;
    s = -1;
    repeat (44) @(posedge clk_i);
    foreach (txq[i]) begin
      if (s < 0 && txq[i] === 1'b0) begin
        s = i;
      end
    end
    check({31'h0, s >= 0}, {31'h0, exp});
    if (s >= 0) begin
      for (int k = 0; k < 10; k++) begin
        check({31'h0, txq[s + k * BC + BC / 2]}, {31'h0, k == 9 || (k != 0 && k[0])});
      end
    end
  endtask

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      start(i[4:0], 5'h1F);
      expect_cfg(i[4:0]);
    end
    start(5'h1A, 5'h1F);
    frame(1'b0);
    start(5'h1E, 5'h1F);
    frame(1'b1);
    start(5'h01, 5'h00);
    expect_cfg(bsc_pkg::STRAP_DEFAULT);
    frame(1'b1);
    wig <= 1'b1;
    repeat (4) @(posedge clk_i);
    expect_cfg(bsc_pkg::STRAP_DEFAULT);
    // Muted reprint stays silent; lane 0 off leaves mute set
    bus(1'b1, 4'h4, 32'h2, 4'hF);
    txq.delete();
    bus(1'b1, 4'h4, 32'h3, 4'hF);
    frame(1'b0);
    bus(1'b1, 4'h4, 32'h0, 4'hE);
    bus(1'b0, 4'h4, 32'h0, 4'hF);
    check(v, 32'h2);
    bus(1'b1, 4'h4, 32'h0, 4'hF);
    txq.delete();
    bus(1'b1, 4'h4, 32'h1, 4'hF);
    frame(1'b1);
    bus(1'b1, 4'hC, 32'hFFFFFFFF, 4'hF);
    bus(1'b0, 4'hC, 32'h0, 4'hF);
    check(v, 32'h0);
    summarize();
  end

  // Whole run needs about 810 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    $display("mismatch at %0t: watchdog ran out", $time);
    summarize();
  end
endmodule
`default_nettype wire
